// >>> opt_consts.svh
`ifndef OPT_CONSTS_SVH
`define OPT_CONSTS_SVH

// ==========================================================
// Timing
`define OPT_CLK_PERIOD_NS 4
`define OPT_TICK_US       10
`define OPT_TICK_CYC      (`OPT_TICK_US * 1000 / `OPT_CLK_PERIOD_NS)
`define OPT_US_PER_TICK   32'h0000000A

// ==========================================================
// Register byte offsets
`define OPT_ADDR_CTRL     5'h00
`define OPT_ADDR_CYCLE    5'h04
`define OPT_ADDR_HIGH     5'h08
`define OPT_ADDR_REPS     5'h0C
`define OPT_ADDR_STATUS   5'h10
`define OPT_ADDR_IRQ_STAT 5'h14
`define OPT_ADDR_IRQ_CLR  5'h18
`define OPT_ADDR_IRQ_EN   5'h1C

// ==========================================================
// Field positions of the request word
`define OPT_CTRL_MODE_LSB 0
`define OPT_CTRL_LVL_BIT  4
`define OPT_CTRL_KIND_LSB 8
`define OPT_CTRL_IDX_LSB  16

// Interrupt bits
`define OPT_IRQ_DONE      0
`define OPT_IRQ_BAD       1

// Output ranges
`define OPT_DIG_FIRST     4'h8
`define OPT_DIG_LAST      4'hF
`define OPT_AXIS_LAST     4'h4
`define OPT_NUM_DIG       8
`define OPT_NUM_AXIS      5

`endif

// >>> opt_pkg.sv
package opt_pkg;
  typedef enum logic [1:0] {
    OPT_MODE_OFF,
    OPT_MODE_ONCE,
    OPT_MODE_REPEAT,
    OPT_MODE_BAD
  } opt_mode_t;

  typedef enum logic [1:0] {
    OPT_KIND_DIG,
    OPT_KIND_AXIS,
    OPT_KIND_PAIR,
    OPT_KIND_BAD
  } opt_kind_t;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_ONCE,
    ST_HIGH,
    ST_LOW
  } opt_state_t;
endpackage : opt_pkg

// >>> opt_pulse_timer.sv
// Notes on behaviour
// - A mode 0 request stops the timer and releases every output, whatever target it names.
// - Mode 1 drives the initial level for the cycle period, then flips it once.
// - Mode 2 holds the initial level for the high interval, flips, flips back at cycle end, repeats.
// - Time runs in 10 us ticks and requested times are divided by ten, remainder dropped.
// - Cycle period and high interval are given in microseconds.
// - A timed request starts by driving the target to its initial level.
// - Target kind 0 drives digital output 8 to 15 chosen by the index.
// - Target kind 1 drives the enable output of axis 0 to 4 chosen by the index.
// - Target kind 2 drives axis n enable together with digital output 8 plus n.
// - A read-only flag is true once the latest request has finished.
`timescale 1ns/1ps
`default_nettype none
`include "opt_consts.svh"

module opt_pulse_timer (
  input  wire logic        i_ref_clk,
  input  wire logic        i_rst_n,
  input  wire logic [4:0]  i_address,
  input  wire logic        i_read,
  input  wire logic        i_write,
  input  wire logic [31:0] i_writedata,
  output logic      [31:0] o_readdata,
  output logic             o_waitrequest,
  output logic      [7:0]  o_dig_out,
  output logic      [7:0]  o_dig_drive,
  output logic      [4:0]  o_axis_en,
  output logic      [4:0]  o_axis_drive,
  output logic             o_irq
);
  import opt_pkg::*;

  localparam logic [11:0] TICK_LAST = 12'(`OPT_TICK_CYC - 1);

  // ========================================================
  // Bus slave: one wait cycle, then the answer
  logic        take;
  logic [31:0] cyc_us;
  logic [31:0] high_us;
  logic [15:0] reps;
  logic [1:0]  irq_stat;
  logic [1:0]  irq_en;
  logic [1:0]  irq_clr;

  assign take = (i_read | i_write) & ~o_waitrequest;

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      o_waitrequest <= 1'b1;
    end else begin
      o_waitrequest <= ~((i_read | i_write) & o_waitrequest);
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      cyc_us  <= 32'h00000000;
      high_us <= 32'h00000000;
      reps    <= 16'h0000;
      irq_en  <= 2'h0;
    end else if (take && i_write) begin
      unique case (i_address)
        `OPT_ADDR_CYCLE:  cyc_us  <= i_writedata;
        `OPT_ADDR_HIGH:   high_us <= i_writedata;
        `OPT_ADDR_REPS:   reps    <= i_writedata[15:0];
        `OPT_ADDR_IRQ_EN: irq_en  <= i_writedata[1:0];
        default: ;
      endcase
    end
  end

  // ========================================================
  // Request decode
  logic      go;
  opt_mode_t req_mode;
  opt_kind_t req_kind;
  logic [3:0] req_idx;
  logic       req_lvl;
  logic       tgt_ok;
  logic [7:0] next_dmask;
  logic [4:0] next_emask;

  assign go       = take & i_write & (i_address == `OPT_ADDR_CTRL);
  assign req_mode = opt_mode_t'(i_writedata[`OPT_CTRL_MODE_LSB +: 2]);
  assign req_kind = opt_kind_t'(i_writedata[`OPT_CTRL_KIND_LSB +: 2]);
  assign req_idx  = i_writedata[`OPT_CTRL_IDX_LSB +: 4];
  assign req_lvl  = i_writedata[`OPT_CTRL_LVL_BIT];

  always_comb begin
    next_dmask = 8'h00;
    next_emask = 5'h00;
    tgt_ok     = 1'b0;
    unique case (req_kind)
      OPT_KIND_DIG: begin
        tgt_ok     = (req_idx >= `OPT_DIG_FIRST);
        next_dmask = 8'h01 << req_idx[2:0];
      end
      OPT_KIND_AXIS: begin
        tgt_ok     = (req_idx <= `OPT_AXIS_LAST);
        next_emask = 5'(5'h01 << req_idx[2:0]);
      end
      OPT_KIND_PAIR: begin
        tgt_ok     = (req_idx <= `OPT_AXIS_LAST);
        next_emask = 5'(5'h01 << req_idx[2:0]);
        next_dmask = 8'h01 << req_idx[2:0];
      end
      OPT_KIND_BAD: tgt_ok = 1'b0;
    endcase
    if (!tgt_ok) begin
      next_dmask = 8'h00;
      next_emask = 5'h00;
    end
  end

  logic start;
  logic stop;
  logic bad;
  assign stop  = go & (req_mode == OPT_MODE_OFF);
  assign start = go & tgt_ok & (req_mode == OPT_MODE_ONCE || req_mode == OPT_MODE_REPEAT);
  assign bad   = go & ~stop & ~start;

  // ========================================================
  // Timer core
  opt_state_t  state;
  logic [11:0] pre_cnt;
  logic [31:0] tcnt;
  logic [31:0] cyc_t;
  logic [31:0] high_t;
  logic [31:0] target;
  logic [15:0] reps_left;
  logic        lvl;
  logic        done;
  logic        tick;
  logic        expire;
  logic        fin;

  assign tick = (state != ST_IDLE) & (pre_cnt == TICK_LAST);

  // A high interval at or above the period leaves a low phase of one tick
  always_comb begin
    unique case (state)
      ST_HIGH: target = high_t;
      ST_LOW:  target = (cyc_t > high_t) ? cyc_t - high_t : 32'h00000000;
      default: target = cyc_t;
    endcase
  end

  assign expire = tick & ((tcnt + 32'h00000001) >= target);
  assign fin    = expire & ((state == ST_ONCE) | ((state == ST_LOW) & (reps_left == 16'h0001)));

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      state        <= ST_IDLE;
      pre_cnt      <= 12'h000;
      tcnt         <= 32'h00000000;
      cyc_t        <= 32'h00000000;
      high_t       <= 32'h00000000;
      reps_left    <= 16'h0000;
      lvl          <= 1'b0;
      done         <= 1'b1;
      o_dig_drive  <= 8'h00;
      o_axis_drive <= 5'h00;
    end else if (stop) begin
      state        <= ST_IDLE;
      o_dig_drive  <= 8'h00;
      o_axis_drive <= 5'h00;
      done         <= 1'b1;
    end else if (start) begin
      // Divide at load time so the running path only compares
      cyc_t        <= cyc_us / `OPT_US_PER_TICK;
      high_t       <= high_us / `OPT_US_PER_TICK;
      reps_left    <= (reps == 16'h0000) ? 16'h0001 : reps;
      lvl          <= req_lvl;
      o_dig_drive  <= next_dmask;
      o_axis_drive <= next_emask;
      pre_cnt      <= 12'h000;
      tcnt         <= 32'h00000000;
      done         <= 1'b0;
      state        <= (req_mode == OPT_MODE_ONCE) ? ST_ONCE : ST_HIGH;
    end else if (state != ST_IDLE) begin
      pre_cnt <= tick ? 12'h000 : pre_cnt + 12'h001;
      tcnt    <= expire ? 32'h00000000 : (tick ? tcnt + 32'h00000001 : tcnt);
      if (expire) begin
        lvl <= ~lvl;
        unique case (state)
          ST_ONCE: state <= ST_IDLE;
          ST_HIGH: state <= ST_LOW;
          ST_LOW: begin
            reps_left <= reps_left - 16'h0001;
            state     <= (reps_left == 16'h0001) ? ST_IDLE : ST_HIGH;
          end
          default: state <= ST_IDLE;
        endcase
        if (fin) begin
          done <= 1'b1;
        end
      end
    end
  end

  // ========================================================
  // Output pins; a released pin rests low
  genvar g;
  for (g = 0; g < `OPT_NUM_DIG; g++) begin : g_dig
    always_ff @(posedge i_ref_clk) begin
      if (!i_rst_n) begin
        o_dig_out[g] <= 1'b0;
      end else begin
        o_dig_out[g] <= o_dig_drive[g] & lvl;
      end
    end
  end
  for (g = 0; g < `OPT_NUM_AXIS; g++) begin : g_axis
    always_ff @(posedge i_ref_clk) begin
      if (!i_rst_n) begin
        o_axis_en[g] <= 1'b0;
      end else begin
        o_axis_en[g] <= o_axis_drive[g] & lvl;
      end
    end
  end

  // ========================================================
  // Interrupts: a new event wins over a clear in the same cycle
  assign irq_clr = (take && i_write && i_address == `OPT_ADDR_IRQ_CLR) ? i_writedata[1:0] : 2'h0;

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      irq_stat <= 2'h0;
      o_irq    <= 1'b0;
    end else begin
      irq_stat <= (irq_stat & ~irq_clr) | {bad, fin};
      o_irq    <= |(irq_stat & irq_en);
    end
  end

  // ========================================================
  // Read data, loaded while the wait cycle is shown
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      o_readdata <= 32'h00000000;
    end else if (i_read && o_waitrequest) begin
      unique case (i_address)
        `OPT_ADDR_CYCLE:    o_readdata <= cyc_us;
        `OPT_ADDR_HIGH:     o_readdata <= high_us;
        `OPT_ADDR_REPS:     o_readdata <= {16'h0000, reps};
        `OPT_ADDR_STATUS:   o_readdata <= {29'h00000000, lvl, state != ST_IDLE, done};
        `OPT_ADDR_IRQ_STAT: o_readdata <= {30'h00000000, irq_stat};
        `OPT_ADDR_IRQ_EN:   o_readdata <= {30'h00000000, irq_en};
        default:            o_readdata <= 32'h00000000;
      endcase
    end
  end

  // ========================================================
  // Checks
  property p_stop;
    @(posedge i_ref_clk) disable iff (!i_rst_n)
      stop |=> state == ST_IDLE && o_dig_drive == 8'h00 && o_axis_drive == 5'h00;
  endproperty
  a_stop: assert property (p_stop) else $error("stop did not release");

  property p_once;
    @(posedge i_ref_clk) disable iff (!i_rst_n)
      (state == ST_ONCE && expire && !go) |=> done && lvl != $past(lvl);
  endproperty
  a_once: assert property (p_once) else $error("single shot end wrong");

  property p_high_low;
    @(posedge i_ref_clk) disable iff (!i_rst_n)
      (state == ST_HIGH && expire && !go) |=> state == ST_LOW && lvl != $past(lvl);
  endproperty
  a_high_low: assert property (p_high_low) else $error("high phase end wrong");

  property p_tick;
    @(posedge i_ref_clk) disable iff (!i_rst_n)
      (tick && !go) |=> pre_cnt == 12'h000 ##1 !tick [*8];
  endproperty
  a_tick: assert property (p_tick) else $error("tick spacing wrong");

  property p_conv;
    @(posedge i_ref_clk) disable iff (!i_rst_n)
      start |=> cyc_t == $past(cyc_us) / 32'h0000000A && high_t == $past(high_us) / 32'h0000000A;
  endproperty
  a_conv: assert property (p_conv) else $error("us to tick wrong");

  property p_init;
    @(posedge i_ref_clk) disable iff (!i_rst_n)
      start |=> lvl == $past(req_lvl);
  endproperty
  a_init: assert property (p_init) else $error("initial level wrong");

  property p_dig;
    @(posedge i_ref_clk) disable iff (!i_rst_n)
      (start && req_kind == OPT_KIND_DIG) |=>
        o_dig_drive == (8'h01 << ($past(req_idx) - 4'h8)) && o_axis_drive == 5'h00;
  endproperty
  a_dig: assert property (p_dig) else $error("digital select wrong");

  property p_axis;
    @(posedge i_ref_clk) disable iff (!i_rst_n)
      (start && req_kind == OPT_KIND_AXIS) |=> o_dig_drive == 8'h00 && $onehot(o_axis_drive);
  endproperty
  a_axis: assert property (p_axis) else $error("axis select wrong");

  property p_pair;
    @(posedge i_ref_clk) disable iff (!i_rst_n)
      (start && req_kind == OPT_KIND_PAIR) |=> o_dig_drive[4:0] == o_axis_drive && $onehot(o_axis_drive)
        ##1 o_dig_out[4:0] == o_axis_en;
  endproperty
  a_pair: assert property (p_pair) else $error("pair select wrong");

  property p_flag;
    @(posedge i_ref_clk) disable iff (!i_rst_n)
      done == (state == ST_IDLE);
  endproperty
  a_flag: assert property (p_flag) else $error("done flag disagrees");

  property p_clear;
    @(posedge i_ref_clk) disable iff (!i_rst_n)
      start |=> !done;
  endproperty
  a_clear: assert property (p_clear) else $error("done not cleared");

  property p_cv_once;
    @(posedge i_ref_clk) disable iff (!i_rst_n) state == ST_ONCE && fin;
  endproperty
  c_cv_once: cover property (p_cv_once);

  property p_cv_rep;
    @(posedge i_ref_clk) disable iff (!i_rst_n) state == ST_LOW && fin;
  endproperty
  c_cv_rep: cover property (p_cv_rep);

  property p_cv_bad;
    @(posedge i_ref_clk) disable iff (!i_rst_n) bad;
  endproperty
  c_cv_bad: cover property (p_cv_bad);

endmodule : opt_pulse_timer

`default_nettype wire

// >>> opt_testbench.sv
`timescale 1ns/1ps
`default_nettype none
`include "opt_consts.svh"

module testbench;
  // ==========================================================
  // Clock, reset, design
  logic        i_ref_clk;
  logic        i_rst_n;
  logic [4:0]  i_address;
  logic        i_read;
  logic        i_write;
  logic [31:0] i_writedata;
  logic [31:0] o_readdata;
  logic        o_waitrequest;
  logic [7:0]  o_dig_out;
  logic [7:0]  o_dig_drive;
  logic [4:0]  o_axis_en;
  logic [4:0]  o_axis_drive;
  logic        o_irq;
  logic [12:0] outs;
  int          failures;
  int          total_checks;
  int          cycles;
  logic [31:0] rd;

  assign outs = {o_axis_en, o_dig_out};

  opt_pulse_timer opt_pulse_timer_inst (
    .i_ref_clk     (i_ref_clk),
    .i_rst_n       (i_rst_n),
    .i_address     (i_address),
    .i_read        (i_read),
    .i_write       (i_write),
    .i_writedata   (i_writedata),
    .o_readdata    (o_readdata),
    .o_waitrequest (o_waitrequest),
    .o_dig_out     (o_dig_out),
    .o_dig_drive   (o_dig_drive),
    .o_axis_en     (o_axis_en),
    .o_axis_drive  (o_axis_drive),
    .o_irq         (o_irq)
  );

  initial begin
    i_ref_clk = 1'b0;
    forever #2 i_ref_clk = ~i_ref_clk;
  end

  // ==========================================================
  // Reporting
  task automatic final_report();
    if (failures == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : final_report

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  // Long enough for all timed scenarios, which need about 40000 cycles
  initial begin
    cycles = 0;
    forever begin
      @(posedge i_ref_clk);
      cycles++;
      if (cycles == 60000) begin
        failures++;
        final_report();
      end
    end
  end

  // ==========================================================
  // Avalon master; an idle cycle follows each access so no strobe is set twice in a step
  task automatic bus_write(input logic [4:0] a, input logic [31:0] d);
    i_address   <= a;
    i_writedata <= d;
    i_write     <= 1'b1;
    @(posedge i_ref_clk);
    while (o_waitrequest) @(posedge i_ref_clk);
    i_write <= 1'b0;
    @(posedge i_ref_clk);
  endtask : bus_write

  task automatic bus_read(input logic [4:0] a, output logic [31:0] d);
    i_address <= a;
    i_read    <= 1'b1;
    @(posedge i_ref_clk);
    while (o_waitrequest) @(posedge i_ref_clk);
    d = o_readdata;
    i_read <= 1'b0;
    @(posedge i_ref_clk);
  endtask : bus_read

  function automatic logic [31:0] mk_ctrl(input int md, input int lvl, input int kd, input int ix);
    return (md & 3) | ((lvl & 1) << `OPT_CTRL_LVL_BIT) | ((kd & 3) << `OPT_CTRL_KIND_LSB)
           | ((ix & 15) << `OPT_CTRL_IDX_LSB);
  endfunction : mk_ctrl

  // Timed requests always carry every field; mode 1 ignores HIGH and REPS
  task automatic start(input int cyc, input int hi, input int reps, input logic [31:0] ctrl);
    bus_write(`OPT_ADDR_CYCLE, cyc);
    bus_write(`OPT_ADDR_HIGH, hi);
    bus_write(`OPT_ADDR_REPS, reps);
    bus_write(`OPT_ADDR_CTRL, ctrl);
    @(posedge i_ref_clk);
  endtask : start

  // Counts cycles until the probed pin changes; the tolerance covers bus polling in between
  task automatic wait_flip(input int sel, input int ticks, input int slack, input string nm);
    logic v;
    int   n;
    int   exp;
    v   = outs[sel];
    n   = 0;
    exp = ticks * `OPT_TICK_CYC;
    while (outs[sel] === v && n < exp + 40) begin
      @(posedge i_ref_clk);
      n++;
    end
    check(nm, (n >= exp - slack) && (n <= exp + 8), 1'b1);
  endtask : wait_flip

  // ==========================================================
  // Scenarios
  task automatic t_reset();
    check("reset pins", {o_dig_out, o_dig_drive, o_axis_en, o_axis_drive, o_irq}, 32'h0);
    bus_read(`OPT_ADDR_STATUS, rd);
    check("reset done", rd[0], 1'b1);
  endtask : t_reset

  task automatic t_once_digital();
    bus_write(`OPT_ADDR_IRQ_EN, 32'h0000_0001);
    start(27, 0, 0, mk_ctrl(1, 1, 0, 14));
    check("dig drive", {o_dig_drive, o_axis_drive}, 13'h0800);
    check("initial on", outs[6], 1'b1);
    bus_read(`OPT_ADDR_STATUS, rd);
    check("busy done", rd[1:0], 2'h2);
    wait_flip(6, 2, 12, "once period");
    check("final off", outs[6], 1'b0);
    bus_read(`OPT_ADDR_STATUS, rd);
    check("done after", rd[0], 1'b1);
    check("irq level", o_irq, 1'b1);
    bus_write(`OPT_ADDR_IRQ_CLR, 32'h0000_0001);
    bus_read(`OPT_ADDR_IRQ_STAT, rd);
    check("irq cleared", {rd[0], o_irq}, 2'h0);
  endtask : t_once_digital

  task automatic t_stop();
    bus_write(`OPT_ADDR_CTRL, 32'h0000_0000);
    @(posedge i_ref_clk);
    @(posedge i_ref_clk);
    check("stop release", {o_dig_drive, o_axis_drive, o_dig_out, o_axis_en}, 32'h0);
    bus_read(`OPT_ADDR_STATUS, rd);
    check("stop done", rd[0], 1'b1);
  endtask : t_stop

  task automatic t_repeat_pair();
    start(30, 15, 2, mk_ctrl(2, 1, 2, 1));
    check("pair drive", {o_dig_drive, o_axis_drive}, 13'h0042);
    check("pair init", {outs[9], outs[1]}, 2'h3);
    for (int r = 0; r < 2; r++) begin
      wait_flip(1, 1, 4, "high interval");
      check("pair low", {outs[9], outs[1]}, 2'h0);
      if (r == 0) begin
        bus_read(`OPT_ADDR_STATUS, rd);
        check("mid busy", rd[0], 1'b0);
      end
      wait_flip(1, 2, 12, "cycle rest");
      check("pair back", {outs[9], outs[1]}, 2'h3);
    end
    bus_read(`OPT_ADDR_STATUS, rd);
    check("repeat done", rd[0], 1'b1);
    t_stop();
  endtask : t_repeat_pair

  // Axis targets are taken as already set up with an enable-capable axis type
  task automatic t_once_axis();
    start(19, 0, 0, mk_ctrl(1, 0, 1, 4));
    check("axis drive", {o_dig_drive, o_axis_drive}, 13'h0010);
    check("axis init", outs[12], 1'b0);
    wait_flip(12, 1, 4, "axis period");
    check("axis final", outs[12], 1'b1);
    t_stop();
  endtask : t_once_axis

  task automatic t_refused();
    logic [31:0] bad [4];
    bad[0] = mk_ctrl(3, 1, 0, 8);
    bad[1] = mk_ctrl(1, 1, 0, 7);
    bad[2] = mk_ctrl(1, 1, 1, 5);
    bad[3] = mk_ctrl(1, 1, 3, 0);
    bus_write(`OPT_ADDR_IRQ_EN, 32'h0000_0000);
    foreach (bad[i]) begin
      bus_write(`OPT_ADDR_IRQ_CLR, 32'h0000_0002);
      start(100, 0, 0, bad[i]);
      check("bad no drive", {o_dig_drive, o_axis_drive, o_irq}, 32'h0);
      bus_read(`OPT_ADDR_IRQ_STAT, rd);
      check("bad flagged", rd[1], 1'b1);
    end
    bus_write(`OPT_ADDR_IRQ_EN, 32'h0000_0002);
    @(posedge i_ref_clk);
    check("bad irq", o_irq, 1'b1);
    bus_write(`OPT_ADDR_IRQ_CLR, 32'h0000_0002);
    @(posedge i_ref_clk);
    check("bad irq clr", o_irq, 1'b0);
  endtask : t_refused

  // Zero repetitions run once; a high interval at the period leaves one low tick
  task automatic t_replace();
    start(40, 40, 0, mk_ctrl(2, 1, 1, 0));
    wait_flip(8, 4, 12, "long high");
    check("min low", outs[8], 1'b0);
    wait_flip(8, 1, 4, "min low end");
    bus_read(`OPT_ADDR_STATUS, rd);
    check("single rep done", rd[0], 1'b1);
    // A new request replaces the running one at once
    start(1000, 0, 0, mk_ctrl(1, 1, 0, 8));
    check("long drive", {o_dig_drive, o_axis_drive}, 13'h0020);
    start(19, 0, 0, mk_ctrl(1, 1, 1, 0));
    check("replace drive", {o_dig_drive, o_axis_drive, o_dig_out[0]}, 14'h0002);
    check("replace init", outs[8], 1'b1);
    wait_flip(8, 1, 4, "replace period");
    t_stop();
  endtask : t_replace

  // Reset in the middle of a long request must release everything
  task automatic t_mid_reset();
    start(1000, 0, 0, mk_ctrl(1, 1, 0, 15));
    check("mid run pin", o_dig_out[7], 1'b1);
    i_rst_n <= 1'b0;
    repeat (2) @(posedge i_ref_clk);
    i_rst_n <= 1'b1;
    @(posedge i_ref_clk);
    check("mid reset pins", {o_dig_out, o_dig_drive, o_axis_en, o_axis_drive, o_irq}, 32'h0);
    bus_read(`OPT_ADDR_STATUS, rd);
    check("mid reset done", rd[1:0], 2'h1);
  endtask : t_mid_reset

  // ==========================================================
  // Main sequence
  initial begin
    failures     = 0;
    total_checks = 0;
    i_rst_n      = 1'b0;
    i_address    = 5'h00;
    i_read       = 1'b0;
    i_write      = 1'b0;
    i_writedata  = 32'h0;
    repeat (6) @(posedge i_ref_clk);
    i_rst_n <= 1'b1;
    @(posedge i_ref_clk);
    t_reset();
    t_once_digital();
    t_stop();
    t_repeat_pair();
    t_once_axis();
    t_replace();
    t_mid_reset();
    t_refused();
    final_report();
  end
endmodule : testbench

`default_nettype wire
